// ### design/fpc_config_regs.sv
// Configuration registers: polarity, silicon version, endpoint config
//
// Overview of operation
// R1: Empty flag pin low when empty if polarity bit 0, high if 1.
// R2: Full flag pin low when full if polarity bit 0, high if 1.
// R3: Strobe polarity bits read-only in ordinary register; reset active low.
// R4: Hidden register at extended address makes strobe bits writable.
// R5: Hidden write: low address at 0x3A, high at 0x3B, data at 0x3C.
// R6: Each byte sent as two data writes, upper nibble first.
// R7: Master reads, modifies and writes the whole polarity value.
// R8: Silicon version: major in upper nibble, minor in lower nibble.
// R9: Endpoint enable bit 7 defaults 1; cleared endpoint ignores traffic.
// R10: Master writes defaults to other bits when clearing enable.
// R11: Direction 0 OUT, 1 IN; endpoints 2,4 OUT and 6,8 IN.
// R12: Bits 5:4 transfer kind; bulk by default.
// R13: Size bit 512 or 1024 for endpoints 2,6; fixed 512 for 4,8.
// R14: Stall bit on bulk endpoint makes every request answer STALL.
// R15: Get Status returns stall of endpoint named in request byte 4.
// R16: Endpoints 2,6 buffering: quad, invalid, double, triple.
// R17: Endpoints 4,8 fixed double buffering, bits read-only.
// R18: Flag level combines condition and polarity, next edge after write; here the pin moves on the second edge, after the polarity register updates.
`timescale 1ns/10ps
module fpc_config_regs
	import fpc_pkg::*;
(
	input wire logic clk_i,
	input wire logic arst_n_i,
	input fpc_cmd_t cmd_i,
	input wire logic [5:0] cmd_addr_i,
	output logic [7:0] rd_data_o,
	input wire logic [3:0] fifo_empty_i,
	input wire logic [3:0] fifo_full_i,
	input wire logic [3:0] flag_is_full_i,
	input wire logic [7:0] flag_fifo_sel_i,
	output logic [3:0] flag_pin_o,
	input wire logic [7:0] status_ep_i,
	output logic status_stall_o,
	input wire logic [1:0] usb_ep_i,
	output logic usb_stall_o,
	output logic usb_ignore_o,
	output fpc_ep_t [3:0] ep_cfg_o,
	output logic [2:0] strobe_polarity_o,
	output logic [7:0] pin_polarity_o
);
	typedef enum {
		FPC_PH_IDLE,
		FPC_PH_UPPER,
		FPC_PH_LOWER
	} fpc_phase_t;

	// Small endpoints (4 and 8) hold size and buffering fixed
	function automatic logic is_small_ep(input int idx);
		return (idx == 1) || (idx == 3);
	endfunction

	function automatic logic [7:0] ep_reset(input int idx);
		return (idx < 2) ? FPC_CFG_OUT_RESET : FPC_CFG_IN_RESET; // [R11]
	endfunction

	// Sources inputs come from off-chip: two-stage synchronisers
	logic [3:0] empty_s1_reg;
	logic [3:0] empty_s2_reg;
	logic [3:0] full_s1_reg;
	logic [3:0] full_s2_reg;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			empty_s1_reg <= 4'h0;
			empty_s2_reg <= 4'h0;
			full_s1_reg <= 4'h0;
			full_s2_reg <= 4'h0;
		end else begin
			empty_s1_reg <= fifo_empty_i;
			empty_s2_reg <= empty_s1_reg;
			full_s1_reg <= fifo_full_i;
			full_s2_reg <= full_s1_reg;
		end
	end

	// Register state
	logic [7:0] pin_polarity_reg;
	logic [7:0] pin_polarity_next;
	logic [7:0] rev_reg;
	logic [7:0] rev_next;
	logic [7:0] cfg_reg [FPC_NUM_EP];
	logic [7:0] cfg_next [FPC_NUM_EP];
	logic [5:0] index_reg;
	logic [5:0] index_next;
	logic [3:0] nib_reg;
	logic [3:0] nib_next;
	fpc_phase_t phase_reg;
	fpc_phase_t phase_next;
	logic [15:0] xaddr_reg;
	logic [15:0] xaddr_next;
	logic [7:0] rd_reg;
	logic [7:0] rd_next;

	// Command decode: address write picks index, two data writes form a byte
	logic byte_done;
	logic [7:0] wr_byte;

	always_comb begin
		index_next = index_reg;
		nib_next = nib_reg;
		phase_next = phase_reg;
		byte_done = 1'b0;
		wr_byte = {nib_reg, cmd_i.data[3:0]};
		if (cmd_i.addr_wr) begin
			index_next = cmd_addr_i;
			phase_next = FPC_PH_UPPER;
		end else if (cmd_i.data_wr) begin
			unique case (phase_reg)
				FPC_PH_UPPER: begin
					nib_next = cmd_i.data[3:0]; // [R6]
					phase_next = FPC_PH_LOWER;
				end
				FPC_PH_LOWER: begin
					byte_done = 1'b1; // [R6]
					phase_next = FPC_PH_UPPER;
				end
				FPC_PH_IDLE: begin
					phase_next = FPC_PH_IDLE;
				end
			endcase
		end
	end

	always_comb begin
		pin_polarity_next = pin_polarity_reg;
		rev_next = rev_reg;
		xaddr_next = xaddr_reg;
		for (int i = 0; i < FPC_NUM_EP; i++) begin
			cfg_next[i] = cfg_reg[i];
		end
		if (byte_done) begin
			unique case (index_reg)
				FPC_IDX_PIN_POLARITY: begin
					pin_polarity_next = (pin_polarity_reg & FPC_POL_STROBE_MASK)
						| (wr_byte & ~FPC_POL_STROBE_MASK); // [R3]
				end
				FPC_IDX_REV: begin
					rev_next = wr_byte; // [R8]
				end
				FPC_IDX_XLO: begin
					xaddr_next[7:0] = wr_byte; // [R5]
				end
				FPC_IDX_XHI: begin
					xaddr_next[15:8] = wr_byte; // [R5]
				end
				FPC_IDX_XDAT: begin
					if (xaddr_reg == FPC_HIDDEN_ADDR) begin
						pin_polarity_next = wr_byte; // [R4] [R5]
					end
				end
				default: begin
					for (int i = 0; i < FPC_NUM_EP; i++) begin
						if (index_reg == FPC_IDX_EP2 + 6'(i)) begin
							if (is_small_ep(i)) begin
								cfg_next[i] = (cfg_reg[i] & FPC_CFG_FIXED_MASK)
									| (wr_byte & ~FPC_CFG_FIXED_MASK); // [R13] [R17]
							end else begin
								cfg_next[i] = wr_byte; // [R12] [R16]
							end
						end
					end
				end
			endcase
		end
	end

	// Read-back of the index given with the read command; hidden register reads via polarity
	always_comb begin
		rd_next = rd_reg;
		if (cmd_i.rd) begin
			rd_next = 8'h00;
			if (cmd_addr_i == FPC_IDX_PIN_POLARITY) begin
				rd_next = pin_polarity_reg;
			end else if (cmd_addr_i == FPC_IDX_REV) begin
				rd_next = rev_reg; // [R8]
			end
			for (int i = 0; i < FPC_NUM_EP; i++) begin
				if (cmd_addr_i == FPC_IDX_EP2 + 6'(i)) begin
					rd_next = cfg_reg[i];
				end
			end
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pin_polarity_reg <= FPC_POL_RESET; // [R3]
			rev_reg <= FPC_REV_RESET;
			index_reg <= 6'h00;
			nib_reg <= 4'h0;
			phase_reg <= FPC_PH_IDLE;
			xaddr_reg <= 16'h0000;
			rd_reg <= 8'h00;
		end else begin
			pin_polarity_reg <= pin_polarity_next;
			rev_reg <= rev_next;
			index_reg <= index_next;
			nib_reg <= nib_next;
			phase_reg <= phase_next;
			xaddr_reg <= xaddr_next;
			rd_reg <= rd_next;
		end
	end

	genvar g;
	generate
		for (g = 0; g < FPC_NUM_EP; g++) begin : g_ep
			always_ff @(posedge clk_i or negedge arst_n_i) begin
				if (!arst_n_i) begin
					cfg_reg[g] <= ep_reset(g); // [R9] [R11] [R12]
				end else begin
					cfg_reg[g] <= cfg_next[g];
				end
			end
			assign ep_cfg_o[g] = '{
				enabled: cfg_reg[g][FPC_CFG_VALID],
				dir_in: cfg_reg[g][FPC_CFG_DIR],
				kind: cfg_reg[g][FPC_CFG_TYPE_HI:FPC_CFG_TYPE_LO],
				big: cfg_reg[g][FPC_CFG_SIZE],
				stall: cfg_reg[g][FPC_CFG_STALL],
				depth: cfg_reg[g][FPC_CFG_BUF_HI:FPC_CFG_BUF_LO]
			};
		end
	endgenerate

	// USB engine view: disabled endpoints drop traffic, bulk stall answers
	logic [7:0] usb_cfg;
	logic usb_stall_reg;
	logic usb_stall_next;
	logic usb_ignore_reg;
	logic usb_ignore_next;
	logic status_stall_reg;
	logic status_stall_next;
	logic [1:0] status_idx;
	logic status_hit;

	always_comb begin
		usb_cfg = cfg_reg[usb_ep_i];
		usb_ignore_next = ~usb_cfg[FPC_CFG_VALID]; // [R9]
		usb_stall_next = usb_cfg[FPC_CFG_VALID] & usb_cfg[FPC_CFG_STALL]
			& (usb_cfg[FPC_CFG_TYPE_HI:FPC_CFG_TYPE_LO] == FPC_TYPE_BULK);
		// Endpoint number 2/4/6/8 in low bits, direction in bit 7
		status_idx = 2'(status_ep_i[3:1] - 3'h1);
		status_hit = (status_ep_i[3:0] == 4'h2 || status_ep_i[3:0] == 4'h4
			|| status_ep_i[3:0] == 4'h6 || status_ep_i[3:0] == 4'h8)
			&& (status_ep_i[7] == cfg_reg[status_idx][FPC_CFG_DIR]);
		status_stall_next = status_hit
			& cfg_reg[status_idx][FPC_CFG_STALL]; // [R15]
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			usb_stall_reg <= 1'b0;
			usb_ignore_reg <= 1'b0;
			status_stall_reg <= 1'b0;
		end else begin
			usb_stall_reg <= usb_stall_next; // [R14]
			usb_ignore_reg <= usb_ignore_next;
			status_stall_reg <= status_stall_next;
		end
	end

	// Flag pin sources: pick empty or full of the chosen FIFO
	fpc_flag_t [3:0] flag_src;

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			flag_src[i].is_full = flag_is_full_i[i];
			flag_src[i].cond = flag_is_full_i[i]
				? full_s2_reg[flag_fifo_sel_i[2*i +: 2]]
				: empty_s2_reg[flag_fifo_sel_i[2*i +: 2]];
		end
	end

	fpc_flag_drive u_flag (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.empty_flag_polarity_i(pin_polarity_reg[FPC_POL_EF]),
		.full_flag_polarity_i(pin_polarity_reg[FPC_POL_FF]),
		.src_i(flag_src),
		.flag_pin_o(flag_pin_o)
	); // [R18]

	assign rd_data_o = rd_reg;
	assign usb_stall_o = usb_stall_reg;
	assign usb_ignore_o = usb_ignore_reg;
	assign status_stall_o = status_stall_reg;
	assign pin_polarity_o = pin_polarity_reg;
	assign strobe_polarity_o = {pin_polarity_reg[FPC_POL_OE], pin_polarity_reg[FPC_POL_RD],
		pin_polarity_reg[FPC_POL_WR]};
endmodule

// ### include/fpc_pkg.sv
// Package: register map, field layout, reset values and command codes
package fpc_pkg;
	// Command-interface register indices
	localparam logic [5:0] FPC_IDX_PIN_POLARITY = 6'h04;
	localparam logic [5:0] FPC_IDX_REV = 6'h05;
	localparam logic [5:0] FPC_IDX_EP2 = 6'h06;
	localparam logic [5:0] FPC_IDX_EP4 = 6'h07;
	localparam logic [5:0] FPC_IDX_EP6 = 6'h08;
	localparam logic [5:0] FPC_IDX_EP8 = 6'h09;
	localparam logic [5:0] FPC_IDX_XLO = 6'h3a;
	localparam logic [5:0] FPC_IDX_XHI = 6'h3b;
	localparam logic [5:0] FPC_IDX_XDAT = 6'h3c;
	// Extended address of the hidden polarity register
	localparam logic [15:0] FPC_HIDDEN_ADDR = 16'he609;
	// Polarity field positions
	localparam int FPC_POL_FF = 0;
	localparam int FPC_POL_EF = 1;
	localparam int FPC_POL_WR = 2;
	localparam int FPC_POL_RD = 3;
	localparam int FPC_POL_OE = 4;
	localparam logic [7:0] FPC_POL_STROBE_MASK = 8'h1c;
	localparam logic [7:0] FPC_POL_RESET = 8'h00;
	// Endpoint config field positions
	localparam int FPC_CFG_VALID = 7;
	localparam int FPC_CFG_DIR = 6;
	localparam int FPC_CFG_TYPE_HI = 5;
	localparam int FPC_CFG_TYPE_LO = 4;
	localparam int FPC_CFG_SIZE = 3;
	localparam int FPC_CFG_STALL = 2;
	localparam int FPC_CFG_BUF_HI = 1;
	localparam int FPC_CFG_BUF_LO = 0;
	// Bits fixed in the small endpoints: size and buffering
	localparam logic [7:0] FPC_CFG_FIXED_MASK = 8'h0b;
	localparam logic [7:0] FPC_CFG_OUT_RESET = 8'ha2;
	localparam logic [7:0] FPC_CFG_IN_RESET = 8'he2;
	// Silicon version, arbitrary value
	localparam logic [7:0] FPC_REV_RESET = 8'h21;
	// Transfer kinds and buffer depths
	localparam logic [1:0] FPC_TYPE_INVALID = 2'b00;
	localparam logic [1:0] FPC_TYPE_ISO = 2'b01;
	localparam logic [1:0] FPC_TYPE_BULK = 2'b10;
	localparam logic [1:0] FPC_TYPE_INT = 2'b11;
	localparam logic [1:0] FPC_BUF_QUAD = 2'b00;
	localparam logic [1:0] FPC_BUF_BAD = 2'b01;
	localparam logic [1:0] FPC_BUF_DOUBLE = 2'b10;
	localparam logic [1:0] FPC_BUF_TRIPLE = 2'b11;
	localparam int FPC_NUM_EP = 4;

	// Command write from the external master
	typedef struct packed {
		logic addr_wr;
		logic data_wr;
		logic rd;
		logic [7:0] data;
	} fpc_cmd_t;

	// Decoded endpoint settings for the USB engine
	typedef struct packed {
		logic enabled;
		logic dir_in;
		logic [1:0] kind;
		logic big;
		logic stall;
		logic [1:0] depth;
	} fpc_ep_t;

	// Flag sources per pin: selects empty or full of the indicated FIFO
	typedef struct packed {
		logic is_full;
		logic cond;
	} fpc_flag_t;
endpackage

// ### design/fpc_flag_drive.sv
// Flag pin polarity driver
`timescale 1ns/10ps
module fpc_flag_drive
	import fpc_pkg::*;
(
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic empty_flag_polarity_i,
	input wire logic full_flag_polarity_i,
	input fpc_flag_t [3:0] src_i,
	output logic [3:0] flag_pin_o
);
	logic [3:0] flag_reg;
	logic [3:0] flag_next;

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			// Asserted level follows the polarity bit; idle is the inverse
			if (src_i[i].is_full) begin
				flag_next[i] = src_i[i].cond ? full_flag_polarity_i
					: ~full_flag_polarity_i; // [R2] [R18]
			end else begin
				flag_next[i] = src_i[i].cond ? empty_flag_polarity_i
					: ~empty_flag_polarity_i; // [R1] [R18]
			end
		end
	end

	// Reset idle level matches default low-active flags
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			flag_reg <= 4'hf;
		end else begin
			flag_reg <= flag_next;
		end
	end

	assign flag_pin_o = flag_reg;
endmodule

// ### tb/fpc_config_regs_props.sv
// Checker for the configuration register block ports
`timescale 1ns/10ps
module fpc_config_regs_props
	import fpc_pkg::*;
(
	input wire logic clk_i,
	input wire logic arst_n_i,
	input fpc_cmd_t cmd_i,
	input wire logic [5:0] cmd_addr_i,
	input wire logic [7:0] rd_data_o,
	input wire logic [1:0] usb_ep_i,
	input wire logic usb_stall_o,
	input wire logic usb_ignore_o,
	input fpc_ep_t [3:0] ep_cfg_o,
	input wire logic [2:0] strobe_polarity_o,
	input wire logic [7:0] pin_polarity_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	fpc_ep_t sel_ep;
	fpc_ep_t rd_ep;
	logic stall_exp;
	logic ignore_exp;
	assign sel_ep = ep_cfg_o[usb_ep_i];
	// Index 6..9 folds onto entries 0..3
	assign rd_ep = ep_cfg_o[cmd_addr_i[1:0] - 2'd2];
	assign stall_exp = sel_ep.enabled && sel_ep.kind == 2'b10 && sel_ep.stall;
	assign ignore_exp = !sel_ep.enabled;
	// Index of the last address write, to tell which path moved a bit
	logic [5:0] last_idx;
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			last_idx <= 6'h00;
		end else if (cmd_i.addr_wr) begin
			last_idx <= cmd_addr_i;
		end
	end
	AST_STROBE_HOLD: assert property (
		$changed(strobe_polarity_o) |-> $past(last_idx) == FPC_IDX_XDAT)
		else $error("strobe bits moved outside hidden write");
	AST_STROBE_MAP: assert property (
		strobe_polarity_o == pin_polarity_o[4:2]) else $error("strobe map");
	AST_FIXED_SMALL: assert property (
		ep_cfg_o[1][3:0] ==? 4'b0?10 && ep_cfg_o[3][3:0] ==? 4'b0?10)
		else $error("small endpoint fixed bits");
	AST_STALL: assert property (
		1 |=> usb_stall_o == $past(stall_exp)) else $error("stall answer");
	AST_IGNORE: assert property (
		1 |=> usb_ignore_o == $past(ignore_exp)) else $error("ignore");
	AST_RD_POL: assert property (
		cmd_i.rd && cmd_addr_i == FPC_IDX_PIN_POLARITY
		|=> rd_data_o == $past(pin_polarity_o)) else $error("polarity read");
	AST_RD_EP: assert property (
		cmd_i.rd && cmd_addr_i inside {[6'h06:6'h09]}
		|=> rd_data_o == $past(rd_ep)) else $error("endpoint read");
	AST_POL_CAUSE: assert property (
		$changed(pin_polarity_o) |-> $past(cmd_i.data_wr))
		else $error("polarity moved without write");
	AST_EP_CAUSE: assert property (
		$changed(ep_cfg_o) |-> $past(cmd_i.data_wr))
		else $error("endpoint moved without write");
	cover property (usb_stall_o);
	cover property (usb_ignore_o);
	cover property (cmd_i.addr_wr && cmd_addr_i == FPC_IDX_XDAT);
endmodule

bind fpc_config_regs fpc_config_regs_props i_props (.clk_i, .arst_n_i,
	.cmd_i, .cmd_addr_i, .rd_data_o, .usb_ep_i, .usb_stall_o, .usb_ignore_o,
	.ep_cfg_o, .strobe_polarity_o, .pin_polarity_o);

// ### tb/fpc_master_model.sv
// External master model for the indexed command interface
`timescale 1ns/10ps
module fpc_master_model
	import fpc_pkg::*;
(
	input wire logic clk_i,
	input wire logic [7:0] rd_data_i,
	output fpc_cmd_t cmd_o,
	output logic [5:0] addr_o
);
	initial begin
		cmd_o = '0;
		addr_o = 6'h3f;
	end
	task automatic step(input logic [2:0] s, input logic [7:0] d,
		input logic [5:0] a);
		@(negedge clk_i);
		cmd_o = {s, d};
		addr_o = a;
	endtask
	// Unused lines flip so stale values cannot pass
	task automatic idle();
		step(3'b000, ~cmd_o.data, ~addr_o);
	endtask
	task automatic wr_reg(input logic [5:0] idx, input logic [7:0] v);
		step(3'b100, ~v, idx);
		step(3'b010, {4'h0, v[7:4]}, ~idx);
		step(3'b010, {4'h0, v[3:0]}, ~idx);
		idle();
	endtask
	task automatic rd_reg(input logic [5:0] idx, output logic [7:0] v);
		step(3'b001, ~cmd_o.data, idx);
		idle();
		v = rd_data_i;
	endtask
	task automatic wr_hidden(input logic [15:0] a, input logic [7:0] v);
		wr_reg(FPC_IDX_XLO, a[7:0]);
		wr_reg(FPC_IDX_XHI, a[15:8]);
		wr_reg(FPC_IDX_XDAT, v);
	endtask
	task automatic set_strobe(input logic [2:0] m);
		logic [7:0] v;
		rd_reg(FPC_IDX_PIN_POLARITY, v);
		wr_hidden(FPC_HIDDEN_ADDR, (v & 8'he3) | {3'h0, m, 2'h0});
	endtask
	task automatic clear_ep(input logic [5:0] idx, input logic [7:0] dflt);
		wr_reg(idx, {1'b0, dflt[6:0]});
	endtask
endmodule

// ### tb/fpc_config_regs_bench.sv
// Self-checking bench for the configuration register block
`timescale 1ns/10ps
module fpc_config_regs_bench
	import fpc_pkg::*;
();
	logic clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	fpc_cmd_t cmd;
	logic [5:0] addr;
	logic [7:0] rd_data, v, pol, stat = 8'h00;
	logic [7:0] sel = 8'he4;
	logic [3:0] emp = 4'h0, ful = 4'h0, isf = 4'h5, pins, xp;
	logic [1:0] uep = 2'd2;
	logic [2:0] strobe;
	logic stall, ign, sstall;
	int err_total = 0;
	int comparisons = 0;
	always #4 clk_i = ~clk_i;
	fpc_config_regs i_dut (.clk_i, .arst_n_i, .cmd_i(cmd), .cmd_addr_i(addr),
		.rd_data_o(rd_data), .fifo_empty_i(emp), .fifo_full_i(ful),
		.flag_is_full_i(isf), .flag_fifo_sel_i(sel), .flag_pin_o(pins),
		.status_ep_i(stat), .status_stall_o(sstall), .usb_ep_i(uep),
		.usb_stall_o(stall), .usb_ignore_o(ign), .ep_cfg_o(),
		.strobe_polarity_o(strobe), .pin_polarity_o(pol));
	fpc_master_model i_mst (.clk_i, .rd_data_i(rd_data), .cmd_o(cmd),
		.addr_o(addr));
	task automatic check(input string name, input logic [7:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic final_report();
		if (err_total == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_i);
		err_total++;
		final_report();
	end
	initial begin
		repeat (4) @(negedge clk_i);
		arst_n_i = 1'b1;
		for (int i = 0; i < 4; i++) begin
			i_mst.rd_reg(FPC_IDX_EP2 + 6'(i), v);
			check("ep_reset", v, i < 2 ? 8'ha2 : 8'he2);
		end
		i_mst.rd_reg(FPC_IDX_REV, v);
		check("rev_reset", v, FPC_REV_RESET);
		i_mst.wr_reg(FPC_IDX_REV, 8'h35);
		i_mst.rd_reg(FPC_IDX_REV, v);
		check("rev", v, 8'h35);
		for (int p = 0; p < 4; p++) begin
			// Strobe bits are offered too and must be dropped
			i_mst.wr_reg(FPC_IDX_PIN_POLARITY, 8'h1c | 8'(p));
			emp = 4'(p * 5);
			ful = 4'(p * 3 + 6);
			isf = ~isf;
			// Odd passes route each pin to the mirrored FIFO
			sel = p[0] ? 8'h1b : 8'he4;
			repeat (5) @(negedge clk_i);
			i_mst.rd_reg(FPC_IDX_PIN_POLARITY, v);
			check("polarity", v, 8'(p));
			for (int k = 0; k < 4; k++)
				xp[k] = isf[k] ? ful[sel[2*k +: 2]] ~^ p[0]
					: emp[sel[2*k +: 2]] ~^ p[1];
			check("flags", {4'h0, pins}, {4'h0, xp});
		end
		i_mst.wr_hidden(16'he608, 8'h1c);
		i_mst.rd_reg(FPC_IDX_PIN_POLARITY, v);
		check("hidden_miss", v, 8'h03);
		i_mst.set_strobe(3'b101);
		i_mst.rd_reg(FPC_IDX_PIN_POLARITY, v);
		check("hidden", v, 8'h17);
		check("strobe", {5'h0, strobe}, 8'h05);
		i_mst.wr_reg(FPC_IDX_PIN_POLARITY, 8'h00);
		i_mst.rd_reg(FPC_IDX_PIN_POLARITY, v);
		check("strobe_kept", v, 8'h14);
		check("pol_out", pol, 8'h14);
		i_mst.wr_reg(FPC_IDX_EP4, 8'hff);
		i_mst.rd_reg(FPC_IDX_EP4, v);
		check("ep4_fixed", v, 8'hf6);
		stat = 8'h86;
		for (int k = 0; k < 4; k++) begin
			i_mst.wr_reg(FPC_IDX_EP2, 8'ha8 | 8'(k));
			i_mst.rd_reg(FPC_IDX_EP2, v);
			check("ep2", v, 8'ha8 | 8'(k));
			i_mst.wr_reg(FPC_IDX_EP6, 8'hc4 | 8'(k << 4));
			repeat (3) @(negedge clk_i);
			check("stall", {7'h0, stall}, {7'h0, k == 2});
			check("status", {7'h0, sstall}, 8'h01);
		end
		stat = 8'h06;
		repeat (3) @(negedge clk_i);
		check("status_dir", {7'h0, sstall}, 8'h00);
		i_mst.clear_ep(FPC_IDX_EP6, 8'he2);
		repeat (3) @(negedge clk_i);
		check("ignore", {6'h0, ign, stall}, 8'h02);
		// Bulk OUT endpoint with stall, watched through another index
		i_mst.wr_reg(FPC_IDX_EP2, 8'ha4);
		uep = 2'd0;
		stat = 8'h02;
		repeat (3) @(negedge clk_i);
		check("ep2_stall", {6'h0, ign, stall}, 8'h01);
		check("status_ep2", {7'h0, sstall}, 8'h01);
		final_report();
	end
endmodule
